// >>> shared/pwda_pkg.sv
// package: constants and types of the pwm d/a waveform output
package pwda_pkg;
  // ==========================================================
  // waveform geometry
  localparam int PWDA_DATA_W       = 14;
  localparam int PWDA_PIDX_W       = 8;
  localparam int PWDA_PIDX_SHORT_W = 6;
  localparam int PWDA_PRE_W        = 3;
  localparam int PWDA_CKS_W        = 2;
  localparam logic [7:0] PWDA_IDX_LAST_LONG  = 8'hff;
  localparam logic [7:0] PWDA_IDX_LAST_SHORT = 8'h3f;
  // ==========================================================
  // bus and register map
  localparam int PWDA_AXI_AW = 32;
  localparam int PWDA_AXI_DW = 32;
  localparam int PWDA_OFF_W  = 4;
  localparam logic [3:0] PWDA_OFF_DATA   = 4'h0;
  localparam logic [3:0] PWDA_OFF_CTRL   = 4'h4;
  localparam logic [3:0] PWDA_OFF_STATUS = 4'h8;
  localparam logic [3:0] PWDA_OFF_COUNT  = 4'hc;
  localparam logic [1:0] PWDA_RESP_OKAY   = 2'b00;
  localparam logic [1:0] PWDA_RESP_SLVERR = 2'b10;
  // ==========================================================
  // control fields
  localparam int PWDA_CTRL_W       = 5;
  localparam int PWDA_CTRL_CFS_BIT = 0;
  localparam int PWDA_CTRL_OS_BIT  = 1;
  localparam int PWDA_CTRL_CKS_LSB = 2;
  localparam int PWDA_CTRL_EN_BIT  = 4;
  localparam logic [4:0]  PWDA_CTRL_RST = 5'h00;
  localparam logic [13:0] PWDA_DATA_RST = 14'h0000;
  // ==========================================================
  // status fields
  localparam int PWDA_ST_PIN_BIT   = 0;
  localparam int PWDA_ST_FIXED_BIT = 1;
  localparam int PWDA_ST_RUN_BIT   = 2;
  localparam int PWDA_ST_PEND_BIT  = 3;
  localparam int PWDA_ST_IDX_LSB   = 8;
  localparam int PWDA_COUNT_W      = 16;
  // ==========================================================
  // generator states
  typedef enum logic [1:0] {
    PWDA_ST_IDLE = 2'b01,
    PWDA_ST_RUN  = 2'b10
  } pwda_state_type;
endpackage

// >>> shared/pwda_if.sv
// interface: settings to the generator and its state back
`timescale 1ns/1ps
interface pwda_if;
  import pwda_pkg::*;
  logic [PWDA_DATA_W-1:0] cfg_value;
  logic                   cfg_cfs;
  logic                   cfg_os;
  logic [PWDA_CKS_W-1:0]  cfg_cks;
  logic                   cfg_en;
  logic                   st_pin;
  logic                   st_fixed;
  logic                   st_run;
  logic [PWDA_PIDX_W-1:0] st_idx;
  logic                   st_load;
  logic                   st_done;
  modport ctl (
    output cfg_value, cfg_cfs, cfg_os, cfg_cks, cfg_en,
    input  st_pin, st_fixed, st_run, st_idx, st_load, st_done
  );
  modport gen (
    input  cfg_value, cfg_cfs, cfg_os, cfg_cks, cfg_en,
    output st_pin, st_fixed, st_run, st_idx, st_load, st_done
  );
endinterface

// >>> rtl/pwda_gen.sv
// pwm d/a waveform generator: counters, pulse spreading, pin level
`timescale 1ns/1ps
module pwda_gen #(
  parameter int DATA_W = pwda_pkg::PWDA_DATA_W
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // settings and state
  pwda_if.gen      bus
);
  import pwda_pkg::*;

  localparam int UW = DATA_W - PWDA_PIDX_SHORT_W;
  localparam int WW = UW + 1;
  localparam logic [UW-1:0] UNIT_LAST_LONG  = {2'b00, {(UW-2){1'b1}}};
  localparam logic [UW-1:0] UNIT_LAST_SHORT = {UW{1'b1}};

  generate
    if (DATA_W < 9 || DATA_W > 16) begin : g_chk
      $error("pwda_gen: DATA_W must lie in 9..16");
    end
  endgenerate

  // ==========================================================
  // state
  pwda_state_type         state_reg, state_next;
  logic [PWDA_PRE_W-1:0]  pre_reg, pre_next;
  logic [UW-1:0]          unit_reg, unit_next;
  logic [PWDA_PIDX_W-1:0] idx_reg, idx_next;
  logic [DATA_W-1:0]      value_reg, value_next;
  logic                   cfs_reg, cfs_next;
  logic                   pin_reg, pin_next;
  logic                   fixed_reg, fixed_next;
  logic                   load_next;
  logic                   done_reg, done_next;

  // ==========================================================
  // pulse spreading: bit-reversed index against the fraction
  logic [PWDA_PIDX_W-1:0]       rev_long;
  logic [PWDA_PIDX_SHORT_W-1:0] rev_short;
  genvar g;
  generate
    for (g = 0; g < PWDA_PIDX_W; g++) begin : g_rev
      assign rev_long[g] = idx_reg[PWDA_PIDX_W-1-g];
      if (g < PWDA_PIDX_SHORT_W) begin : g_short
        assign rev_short[g] = idx_reg[PWDA_PIDX_SHORT_W-1-g];
      end
    end
  endgenerate

  logic [PWDA_PRE_W-1:0]  pre_last;
  logic [UW-1:0]          unit_last;
  logic [PWDA_PIDX_W-1:0] idx_last;
  logic [UW-1:0]          base_w;
  logic                   extra;
  logic [WW-1:0]          width;
  logic                   tick;
  logic                   fixed;
  logic                   low;

  always_comb begin
    pre_last  = PWDA_PRE_W'((4'h1 << bus.cfg_cks) - 4'h1); // R6
    tick      = (pre_reg >= pre_last);
    unit_last = cfs_reg ? UNIT_LAST_SHORT : UNIT_LAST_LONG; // R6
    idx_last  = cfs_reg ? PWDA_IDX_LAST_SHORT
                        : PWDA_IDX_LAST_LONG; // R2
    if (cfs_reg) begin
      base_w = value_reg[DATA_W-1:PWDA_PIDX_SHORT_W];
      extra  = rev_short < value_reg[PWDA_PIDX_SHORT_W-1:0]; // R7
    end else begin
      base_w = UW'(value_reg[DATA_W-1:PWDA_PIDX_W]);
      extra  = rev_long < value_reg[PWDA_PIDX_W-1:0]; // R7
    end
    width = {1'b0, base_w} + WW'(extra); // R1
    fixed = (base_w == '0); // R5
    low   = (state_reg == PWDA_ST_RUN) && !fixed
            && ({1'b0, unit_reg} < width); // R1
  end

  // ==========================================================
  // next state
  always_comb begin
    state_next = state_reg;
    pre_next   = pre_reg;
    unit_next  = unit_reg;
    idx_next   = idx_reg;
    value_next = value_reg;
    cfs_next   = cfs_reg;
    fixed_next = fixed;
    load_next  = 1'b0;
    done_next  = 1'b0;
    pin_next   = ~(low ^ bus.cfg_os); // R3 R4
    case (state_reg)
      PWDA_ST_IDLE: begin
        pre_next  = '0;
        unit_next = '0;
        idx_next  = '0;
        if (bus.cfg_en) begin
          state_next = PWDA_ST_RUN;
          value_next = bus.cfg_value;
          cfs_next   = bus.cfg_cfs;
          load_next  = 1'b1;
        end
      end
      PWDA_ST_RUN: begin
        if (!bus.cfg_en) begin
          state_next = PWDA_ST_IDLE;
        end else if (tick) begin
          pre_next = '0;
          if (unit_reg >= unit_last) begin
            unit_next = '0;
            if (idx_reg >= idx_last) begin
              idx_next   = '0; // R7
              value_next = bus.cfg_value;
              cfs_next   = bus.cfg_cfs;
              load_next  = 1'b1;
              done_next  = 1'b1;
            end else begin
              idx_next = idx_reg + 1'b1;
            end
          end else begin
            unit_next = unit_reg + 1'b1;
          end
        end else begin
          pre_next = pre_reg + 1'b1;
        end
      end
      default: state_next = PWDA_ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= PWDA_ST_IDLE;
      pre_reg   <= '0;
      unit_reg  <= '0;
      idx_reg   <= '0;
      value_reg <= '0;
      cfs_reg   <= 1'b0;
      pin_reg   <= 1'b1;
      fixed_reg <= 1'b1;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      pre_reg   <= pre_next;
      unit_reg  <= unit_next;
      idx_reg   <= idx_next;
      value_reg <= value_next;
      cfs_reg   <= cfs_next;
      pin_reg   <= pin_next;
      fixed_reg <= fixed_next;
      done_reg  <= done_next;
    end
  end

  assign bus.st_pin   = pin_reg;
  assign bus.st_fixed = fixed_reg;
  assign bus.st_run   = (state_reg == PWDA_ST_RUN);
  assign bus.st_idx   = idx_reg;
  // strobe stands in the cycle before the latching edge, so a data write
  // landing on that same edge stays pending
  assign bus.st_load  = load_next;
  assign bus.st_done  = done_reg;
endmodule

// >>> rtl/pwda_top.sv
// pwm d/a waveform output with its axi4-lite register slave
//
// Contract
// R1: data value is total low time summed over one conversion cycle.
// R2: conversion cycle is 256 base pulses, or 64 with base-cycle select set.
// R3: polarity select clear drives the waveform to the pin unchanged.
// R4: polarity select set inverts the pin; data then sets total high time.
// R5: below the minimum data value the pin stays at a constant level.
// R6: prescale and base-cycle selects set resolution and cycle lengths.
// R7: cycles repeat back to back; low time spread over base pulses.
`timescale 1ns/1ps
module pwda_top (
  // clock and reset
  input  wire logic                            aclk,
  input  wire logic                            aresetn,
  // write address channel
  input  wire logic [pwda_pkg::PWDA_AXI_AW-1:0] s_axi_awaddr,
  input  wire logic [2:0]                      s_axi_awprot,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  // write data channel
  input  wire logic [pwda_pkg::PWDA_AXI_DW-1:0] s_axi_wdata,
  input  wire logic [3:0]                      s_axi_wstrb,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  // write response channel
  output logic [1:0]                           s_axi_bresp,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  // read address channel
  input  wire logic [pwda_pkg::PWDA_AXI_AW-1:0] s_axi_araddr,
  input  wire logic [2:0]                      s_axi_arprot,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  // read data channel
  output logic [pwda_pkg::PWDA_AXI_DW-1:0]     s_axi_rdata,
  output logic [1:0]                           s_axi_rresp,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  // waveform pin
  output logic                                 pwm_da_output
);
  import pwda_pkg::*;

  // ==========================================================
  // state
  logic                    aw_held_reg, aw_held_next;
  logic [PWDA_OFF_W-1:0]   aw_off_reg, aw_off_next;
  logic                    aw_ok_reg, aw_ok_next;
  logic                    w_held_reg, w_held_next;
  logic [PWDA_AXI_DW-1:0]  wdata_reg, wdata_next;
  logic [3:0]              wstrb_reg, wstrb_next;
  logic                    bvalid_reg, bvalid_next;
  logic [1:0]              bresp_reg, bresp_next;
  logic                    rvalid_reg, rvalid_next;
  logic [1:0]              rresp_reg, rresp_next;
  logic [PWDA_AXI_DW-1:0]  rdata_reg, rdata_next;
  logic [PWDA_DATA_W-1:0]  data_reg, data_next;
  logic [PWDA_CTRL_W-1:0]  ctrl_reg, ctrl_next;
  logic                    pend_reg, pend_next;
  logic [PWDA_COUNT_W-1:0] count_reg, count_next;

  pwda_if bus ();

  // ==========================================================
  // handshakes
  logic do_write;
  logic wr_mapped;
  logic wr_data;
  logic wr_ctrl;
  logic wr_count;
  logic rd_take;
  logic rd_ok;

  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign do_write      = aw_held_reg && w_held_reg;
  assign rd_take       = s_axi_arvalid && !rvalid_reg;
  assign rd_ok         = (s_axi_araddr[PWDA_AXI_AW-1:PWDA_OFF_W] == '0)
                         && (s_axi_araddr[1:0] == 2'b00);

  always_comb begin
    wr_mapped = 1'b0;
    if (aw_ok_reg) begin
      case (aw_off_reg)
        PWDA_OFF_DATA:   wr_mapped = 1'b1;
        PWDA_OFF_CTRL:   wr_mapped = 1'b1;
        PWDA_OFF_STATUS: wr_mapped = 1'b1;
        PWDA_OFF_COUNT:  wr_mapped = 1'b1;
        default:         wr_mapped = 1'b0;
      endcase
    end
    wr_data  = do_write && wr_mapped && (aw_off_reg == PWDA_OFF_DATA);
    wr_ctrl  = do_write && wr_mapped && (aw_off_reg == PWDA_OFF_CTRL);
    wr_count = do_write && wr_mapped && (aw_off_reg == PWDA_OFF_COUNT);
  end

  // ==========================================================
  // write channel sequencing
  always_comb begin
    aw_held_next = aw_held_reg;
    aw_off_next  = aw_off_reg;
    aw_ok_next   = aw_ok_reg;
    w_held_next  = w_held_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_next = 1'b1;
      aw_off_next  = s_axi_awaddr[PWDA_OFF_W-1:0];
      aw_ok_next   = (s_axi_awaddr[PWDA_AXI_AW-1:PWDA_OFF_W] == '0)
                     && (s_axi_awaddr[1:0] == 2'b00);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_next = 1'b1;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
    end
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = wr_mapped ? PWDA_RESP_OKAY : PWDA_RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
  end

  // ==========================================================
  // software registers
  always_comb begin
    data_next  = data_reg;
    ctrl_next  = ctrl_reg;
    pend_next  = pend_reg;
    count_next = count_reg;
    if (wr_data && wstrb_reg[0]) begin
      data_next[7:0] = wdata_reg[7:0];
    end
    if (wr_data && wstrb_reg[1]) begin
      data_next[PWDA_DATA_W-1:8] = wdata_reg[PWDA_DATA_W-1:8];
    end
    if (wr_ctrl && wstrb_reg[0]) begin
      ctrl_next = wdata_reg[PWDA_CTRL_W-1:0];
    end
    // a new value waits for the next cycle boundary; set wins
    if (bus.st_load) begin
      pend_next = 1'b0;
    end
    if (wr_data) begin
      pend_next = 1'b1;
    end
    // completed cycles; a clear together with a finishing cycle leaves a count of 1
    if (wr_count) begin
      count_next = '0;
    end
    if (bus.st_done) begin
      count_next = (wr_count ? '0 : count_reg) + 1'b1; // R7
    end
  end

  // ==========================================================
  // read channel
  logic [PWDA_AXI_DW-1:0] status_word;

  always_comb begin
    status_word = '0;
    status_word[PWDA_ST_PIN_BIT]   = bus.st_pin;
    status_word[PWDA_ST_FIXED_BIT] = bus.st_fixed;
    status_word[PWDA_ST_RUN_BIT]   = bus.st_run;
    status_word[PWDA_ST_PEND_BIT]  = pend_reg;
    status_word[PWDA_ST_IDX_LSB +: PWDA_PIDX_W] = bus.st_idx;
  end

  always_comb begin
    rvalid_next = rvalid_reg;
    rresp_next  = rresp_reg;
    rdata_next  = rdata_reg;
    if (rd_take) begin
      rvalid_next = 1'b1;
      rresp_next  = PWDA_RESP_OKAY;
      rdata_next  = '0;
      if (!rd_ok) begin
        rresp_next = PWDA_RESP_SLVERR;
      end else begin
        case (s_axi_araddr[PWDA_OFF_W-1:0])
          PWDA_OFF_DATA:   rdata_next = PWDA_AXI_DW'(data_reg);
          PWDA_OFF_CTRL:   rdata_next = PWDA_AXI_DW'(ctrl_reg);
          PWDA_OFF_STATUS: rdata_next = status_word;
          PWDA_OFF_COUNT:  rdata_next = PWDA_AXI_DW'(count_reg);
          default:         rresp_next = PWDA_RESP_SLVERR;
        endcase
      end
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_off_reg  <= '0;
      aw_ok_reg   <= 1'b0;
      w_held_reg  <= 1'b0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= PWDA_RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= PWDA_RESP_OKAY;
      rdata_reg   <= '0;
      data_reg    <= PWDA_DATA_RST;
      ctrl_reg    <= PWDA_CTRL_RST;
      pend_reg    <= 1'b0;
      count_reg   <= '0;
    end else begin
      aw_held_reg <= aw_held_next;
      aw_off_reg  <= aw_off_next;
      aw_ok_reg   <= aw_ok_next;
      w_held_reg  <= w_held_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
      data_reg    <= data_next;
      ctrl_reg    <= ctrl_next;
      pend_reg    <= pend_next;
      count_reg   <= count_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp  = rresp_reg;
  assign s_axi_rdata  = rdata_reg;

  // ==========================================================
  // generator settings and pin
  assign bus.cfg_value = data_reg; // R1
  assign bus.cfg_cfs   = ctrl_reg[PWDA_CTRL_CFS_BIT]; // R2 R6
  assign bus.cfg_os    = ctrl_reg[PWDA_CTRL_OS_BIT]; // R3 R4
  assign bus.cfg_cks   = ctrl_reg[PWDA_CTRL_CKS_LSB +: PWDA_CKS_W]; // R6
  assign bus.cfg_en    = ctrl_reg[PWDA_CTRL_EN_BIT];

  pwda_gen #(
    .DATA_W (PWDA_DATA_W)
  ) u_gen (
    .aclk    (aclk),
    .aresetn (aresetn),
    .bus     (bus.gen)
  );

  // pin comes straight from the generator's output flip-flop
  assign pwm_da_output = bus.st_pin; // R3 R4 R5
endmodule

// >>> verification/pwda_load_model.sv
// partner model: load on the waveform pin that integrates its low time
`timescale 1ns/1ps
module pwda_load_model (
  // clock
  input  wire logic aclk,
  // pin and measurement control
  input  wire logic pin,
  input  wire logic clr,
  // measured figures
  output int        low_cnt,
  output int        fall_cnt
);
  logic prev_reg;
  // ==========================================================
  // integrator and edge counter
  always_ff @(posedge aclk) begin
    if (clr) begin
      low_cnt  <= 0;
      fall_cnt <= 0;
    end else begin
      low_cnt  <= low_cnt + int'(!pin);
      fall_cnt <= fall_cnt + int'(prev_reg && !pin);
    end
    prev_reg <= pin;
  end
endmodule

// >>> verification/pwda_chk.sv
// checker: bus handshakes and pin level of the pwm d/a output
`timescale 1ns/1ps
module pwda_chk (
  // clock and reset
  input wire logic                             aclk,
  input wire logic                             aresetn,
  // bus
  input wire logic                             s_axi_awvalid,
  input wire logic                             s_axi_awready,
  input wire logic                             s_axi_wvalid,
  input wire logic                             s_axi_wready,
  input wire logic [1:0]                       s_axi_bresp,
  input wire logic                             s_axi_bvalid,
  input wire logic                             s_axi_bready,
  input wire logic [pwda_pkg::PWDA_AXI_AW-1:0] s_axi_araddr,
  input wire logic                             s_axi_arvalid,
  input wire logic                             s_axi_arready,
  input wire logic [pwda_pkg::PWDA_AXI_DW-1:0] s_axi_rdata,
  input wire logic [1:0]                       s_axi_rresp,
  input wire logic                             s_axi_rvalid,
  input wire logic                             s_axi_rready,
  // pin
  input wire logic                             pwm_da_output
);
  import pwda_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // assertions
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while read data pending");
  a_aw_refused: assert property
    (s_axi_bvalid |-> !(s_axi_awready || s_axi_wready))
    else $error("write taken while response pending");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_rd_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data changed before taken");
  a_rd_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data held after taken");
  a_wr_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response changed before taken");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_bad_addr: assert property (s_axi_arvalid && s_axi_arready &&
    (s_axi_araddr[31:4] != 0 || s_axi_araddr[1:0] != 0) |=>
    s_axi_rresp == PWDA_RESP_SLVERR && s_axi_rdata == 0)
    else $error("unmapped read not refused");
  a_pin_idle: assert property ($rose(aresetn) |-> pwm_da_output)
    else $error("pin not idle high after reset");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == PWDA_RESP_SLVERR);
  c_pulse: cover property ($fell(pwm_da_output));
endmodule

bind pwda_top pwda_chk chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .pwm_da_output);

// >>> verification/pwda_top_tb.sv
// testbench: register access and pin waveform of the pwm d/a output
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
  mismatches++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp); end end
module pwda_top_tb;
  import pwda_pkg::*;
  // ==========================================================
  // signals
  logic        aclk, aresetn, load_clr;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, pwm_da_output;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          load_low, load_falls, mismatches, n_checks;
  pwda_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pwm_da_output);
  pwda_load_model load_u (.aclk, .pin(pwm_da_output), .clr(load_clr),
    .low_cnt(load_low), .fall_cnt(load_falls));
  // ==========================================================
  // closing and bus tasks
  task automatic wrap_up;
    if (mismatches == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic timed_out;
    mismatches++;
    $display("CHECK FAILED t=%0t bus timeout", $time);
    wrap_up();
  endtask
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d,
                           input logic [1:0] exp);
    logic hs_aw, hs_w, hs_b;
    int   n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    hs_b = 1'b0;
    n = 0;
    while (!hs_b) begin
      @(negedge aclk);
      hs_aw = s_axi_awvalid && s_axi_awready;
      hs_w = s_axi_wvalid && s_axi_wready;
      hs_b = s_axi_bvalid && s_axi_bready;
      if (hs_b) `CHK(s_axi_bresp, exp)
      @(posedge aclk);
      if (hs_aw) s_axi_awvalid <= 1'b0;
      if (hs_w) s_axi_wvalid <= 1'b0;
      n++;
      if (n > 50) timed_out();
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [31:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    logic hs_ar, hs_r;
    int   n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    hs_r = 1'b0;
    n = 0;
    while (!hs_r) begin
      @(negedge aclk);
      hs_ar = s_axi_arvalid && s_axi_arready;
      hs_r = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (hs_ar) s_axi_arvalid <= 1'b0;
      n++;
      if (n > 50) timed_out();
    end
    s_axi_rready <= 1'b0;
  endtask
  // ==========================================================
  // waveform measurement over n clocks after a fresh enable
  task automatic run_wave(input logic [4:0] ctrl, input logic [13:0] val,
                          input int n, output int low, output int falls);
    axi_write({28'h0, PWDA_OFF_CTRL}, 32'h0, PWDA_RESP_OKAY);
    axi_write({28'h0, PWDA_OFF_DATA}, {18'h0, val}, PWDA_RESP_OKAY);
    axi_write({28'h0, PWDA_OFF_CTRL}, {27'h0, ctrl}, PWDA_RESP_OKAY);
    repeat (40) @(posedge aclk);
    load_clr <= 1'b1;
    @(posedge aclk);
    load_clr <= 1'b0;
    repeat (n) @(posedge aclk);
    @(negedge aclk);
    low = load_low;
    falls = load_falls;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    `CHK(pwm_da_output, 1'b1)
    axi_read({28'h0, PWDA_OFF_CTRL}, d, r);
    `CHK(r, PWDA_RESP_OKAY)
    `CHK(d, 32'h0)
    axi_write({28'h0, PWDA_OFF_DATA}, 32'h3fff, PWDA_RESP_OKAY);
    axi_read({28'h0, PWDA_OFF_DATA}, d, r);
    `CHK(d, 32'h3fff)
    axi_read(32'h10, d, r);
    `CHK(r, PWDA_RESP_SLVERR)
    `CHK(d, 32'h0)
    axi_write(32'h22, 32'h5, PWDA_RESP_SLVERR);
  endtask
  task automatic t_long_cycle;
    int low, falls;
    run_wave(5'h10, 14'h0300, 16384, low, falls);
    `CHK(low, 768)
    `CHK(falls, 256)
  endtask
  task automatic t_short_inverted;
    int low, falls;
    run_wave(5'h13, 14'h0155, 16384, low, falls);
    `CHK(16384 - low, 341)
    `CHK(falls, 64)
  endtask
  task automatic t_prescale;
    int low, falls;
    run_wave(5'h14, 14'h0400, 32768, low, falls);
    `CHK(low, 2048)
    `CHK(falls, 256)
  endtask
  task automatic t_slow_prescale;
    int low, falls;
    run_wave(5'h1c, 14'h0100, 1024, low, falls);
    `CHK(low, 16)
    `CHK(falls, 2)
    run_wave(5'h19, 14'h0040, 2048, low, falls);
    `CHK(low, 8)
    `CHK(falls, 2)
  endtask
  task automatic t_fixed;
    int          low, falls;
    logic [31:0] d;
    logic [1:0]  r;
    run_wave(5'h10, 14'h00ff, 2000, low, falls);
    `CHK(low, 0)
    `CHK(falls, 0)
    `CHK(pwm_da_output, 1'b1)
    axi_write({28'h0, PWDA_OFF_DATA}, 32'h0300, PWDA_RESP_OKAY);
    axi_read({28'h0, PWDA_OFF_STATUS}, d, r);
    `CHK(d[PWDA_ST_FIXED_BIT], 1'b1)
    `CHK(d[PWDA_ST_PEND_BIT], 1'b1)
    `CHK(d[PWDA_ST_RUN_BIT], 1'b1)
    axi_write({28'h0, PWDA_OFF_CTRL}, 32'h12, PWDA_RESP_OKAY);
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    `CHK(pwm_da_output, 1'b0)
  endtask
  // ==========================================================
  // clock, reset and main sequence
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  initial begin
    {aresetn, load_clr, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    mismatches = 0;
    n_checks = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_long_cycle();
    t_short_inverted();
    t_prescale();
    t_slow_prescale();
    t_fixed();
    wrap_up();
  end
endmodule
